// [lsi_int_ctrl.sv]
`timescale 1ns/1ps
module lsi_int_ctrl
	import lsi_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Register access from the serial host engine
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	output logic      [7:0]  reg_rd_data,
	// Clear strobe from the command register decode
	input  wire logic        int_clear,
	// Conversion results and thresholds
	input  wire logic        conv_done,
	input  wire logic [15:0] ch0_result,
	input  wire logic [15:0] low_thresh,
	input  wire logic [15:0] high_thresh,
	// Interrupt pin
	output logic             int_n
);
	logic [5:0] cfg_reg;
	logic [5:0] cfg_next;
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic [3:0] run_cnt_reg;
	logic [3:0] run_cnt_next;
	logic       pend_reg;
	logic       pend_next;
	logic [1:0] mode;
	logic [3:0] persist;
	logic       out_win;
	logic       fire;
	logic [4:0] run_inc;

	lsi_cmp_if cmp_bus ();

	// Channel 1 never reaches the comparator
	assign cmp_bus.ch0_result  = ch0_result;
	assign cmp_bus.low_thresh  = low_thresh;
	assign cmp_bus.high_thresh = high_thresh;
	assign out_win             = cmp_bus.out_of_window;

	lsi_window_cmp u_cmp
	(
		.cmp (cmp_bus.cmp)
	);

	assign mode    = cfg_reg[LSI_MODE_MSB:LSI_MODE_LSB];
	assign persist = cfg_reg[LSI_PERS_MSB:LSI_PERS_LSB];
	assign run_inc = {1'b0, run_cnt_reg} + LSI_CNT_STEP;

	// Configuration register; bits 7:6 are not stored, so they read zero
	always_comb
	begin
		cfg_next = cfg_reg;
		if (reg_wr_en && (reg_addr == LSI_CFG_ADDR))
		begin
			cfg_next = reg_wr_data[LSI_MODE_MSB:LSI_PERS_LSB];
		end
	end

	always_comb
	begin
		rd_data_next = rd_data_reg;
		if (reg_rd_en)
		begin
			rd_data_next = (reg_addr == LSI_CFG_ADDR) ? {LSI_RSV_READ, cfg_reg} : LSI_RDATA_RESET;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_reg     <= LSI_CFG_RESET[LSI_MODE_MSB:LSI_PERS_LSB];
			rd_data_reg <= LSI_RDATA_RESET;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// Run counter saturates so long runs never wrap below the limit
	always_comb
	begin
		run_cnt_next = run_cnt_reg;
		if (conv_done)
		begin
			if (!out_win)
			begin
				run_cnt_next = LSI_CNT_ZERO;
			end
			else if (run_cnt_reg != LSI_CNT_MAX)
			begin
				run_cnt_next = run_inc[3:0];
			end
		end
	end

	// Firing decision per persistence setting
	always_comb
	begin
		fire = 1'b0;
		if (conv_done && (mode == LSI_MODE_LEVEL))
		begin
			if (persist == LSI_PERS_EVERY)
			begin
				fire = 1'b1;
			end
			else if (persist == LSI_PERS_ONE)
			begin
				fire = out_win;
			end
			else
			begin
				fire = out_win && (run_inc >= {1'b0, persist});
			end
		end
	end

	// A new event beats a clear in the same cycle; unused modes keep the pin idle
	always_comb
	begin
		pend_next = pend_reg;
		if (mode != LSI_MODE_LEVEL)
		begin
			pend_next = 1'b0;
		end
		else if (fire)
		begin
			pend_next = 1'b1;
		end
		else if (int_clear)
		begin
			pend_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_cnt_reg <= LSI_CNT_ZERO;
			pend_reg    <= 1'b0;
			int_n       <= 1'b1;
		end
		else
		begin
			run_cnt_reg <= run_cnt_next;
			pend_reg    <= pend_next;
			int_n       <= ~pend_next;
		end
	end

	assign reg_rd_data = rd_data_reg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_level_conv;
		conv_done && (mode == LSI_MODE_LEVEL);
	endsequence

	sequence s_pin_low;
		!int_n;
	endsequence

	property p_disabled;
		(mode != LSI_MODE_LEVEL) |=> int_n;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pin active while disabled");

	property p_cfg_write;
		(reg_wr_en && (reg_addr == LSI_CFG_ADDR)) |=> (cfg_reg == $past(reg_wr_data[LSI_MODE_MSB:LSI_PERS_LSB]));
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	property p_every;
		(s_level_conv and (persist == LSI_PERS_EVERY)) |=> s_pin_low;
	endproperty
	a_every: assert property (p_every) else $error("no interrupt after conversion");

	property p_single;
		(s_level_conv and (persist == LSI_PERS_ONE) && out_win) |=> s_pin_low;
	endproperty
	a_single: assert property (p_single) else $error("no interrupt on single outlier");

	property p_run_fire;
		(s_level_conv and (persist > LSI_PERS_ONE) && out_win && (run_inc >= {1'b0, persist})) |=> s_pin_low;
	endproperty
	a_run_fire: assert property (p_run_fire) else $error("run limit reached without interrupt");

	property p_run_early;
		(s_level_conv and (persist > LSI_PERS_ONE) && (run_inc < {1'b0, persist}) && int_n) |=> int_n;
	endproperty
	a_run_early: assert property (p_run_early) else $error("interrupt before run limit");

	property p_hold;
		(!int_n && !int_clear && (mode == LSI_MODE_LEVEL)) |=> !int_n;
	endproperty
	a_hold: assert property (p_hold) else $error("pin released without clear");

	property p_clear;
		(int_clear && !fire) |=> int_n [*1] ##1 1'b1;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not release pin");

	property p_low_edge;
		(s_level_conv and (persist == LSI_PERS_ONE) && (ch0_result == low_thresh)) |=> s_pin_low;
	endproperty
	a_low_edge: assert property (p_low_edge) else $error("low bound equality not outside");

	property p_restart;
		(conv_done && !out_win) |=> (run_cnt_reg == LSI_CNT_ZERO);
	endproperty
	a_restart: assert property (p_restart) else $error("run counter not restarted");
endmodule

// [lsi_pkg.sv]
package lsi_pkg;
	localparam logic [3:0] LSI_CFG_ADDR     = 4'h6;
	localparam logic [7:0] LSI_CFG_RESET    = 8'h00;
	localparam int         LSI_MODE_MSB     = 5;
	localparam int         LSI_MODE_LSB     = 4;
	localparam int         LSI_PERS_MSB     = 3;
	localparam int         LSI_PERS_LSB     = 0;
	localparam logic [1:0] LSI_RSV_READ     = 2'h0;
	localparam logic [1:0] LSI_MODE_OFF     = 2'h0;
	localparam logic [1:0] LSI_MODE_LEVEL   = 2'h1;
	localparam logic [3:0] LSI_PERS_EVERY   = 4'h0;
	localparam logic [3:0] LSI_PERS_ONE     = 4'h1;
	localparam logic [3:0] LSI_CNT_ZERO     = 4'h0;
	localparam logic [3:0] LSI_CNT_MAX      = 4'hF;
	localparam logic [4:0] LSI_CNT_STEP     = 5'h01;
	localparam logic [7:0] LSI_RDATA_RESET  = 8'h00;
endpackage

// [lsi_cmp_if.sv]
`timescale 1ns/1ps
interface lsi_cmp_if;
	logic [15:0] ch0_result;
	logic [15:0] low_thresh;
	logic [15:0] high_thresh;
	logic        out_of_window;

	modport cmp
	(
		input  ch0_result,
		input  low_thresh,
		input  high_thresh,
		output out_of_window
	);
	modport user
	(
		output ch0_result,
		output low_thresh,
		output high_thresh,
		input  out_of_window
	);
endinterface

// [lsi_window_cmp.sv]
`timescale 1ns/1ps
module lsi_window_cmp
	import lsi_pkg::*;
(
	// Comparison operands and verdict
	lsi_cmp_if.cmp cmp
);
	// Equality with the low bound counts as outside
	always_comb
	begin
		cmp.out_of_window = (cmp.ch0_result <= cmp.low_thresh) || (cmp.ch0_result > cmp.high_thresh);
	end
endmodule

// [lsi_host_model.sv]
`timescale 1ns/1ps
module lsi_host_model
(
	// Clock and pin
	input  wire logic       core_clk,
	input  wire logic       int_n,
	// Service setup
	input  wire logic       ack_en,
	input  wire logic [1:0] lag,
	// Clear strobe
	output logic            int_clear
);
	int wait_cnt = 0;
	// Clears only after the pin is seen low, after a lag
	always @(negedge core_clk)
	begin
		int_clear <= 1'b0;
		if (ack_en && int_n === 1'b0 && int_clear !== 1'b1)
		begin
			if (wait_cnt >= lag)
			begin
				int_clear <= 1'b1;
				wait_cnt  <= 0;
			end
			else
				wait_cnt <= wait_cnt + 1;
		end
	end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import lsi_pkg::*;
	logic        core_clk = 0, rst_n = 0, reg_wr_en = 0, reg_rd_en = 0, conv_done = 0, ack_en = 0, exp_n = 1;
	logic [3:0]  reg_addr = 0;
	logic [7:0]  reg_wr_data = 0, reg_rd_data, cfg = 0, d;
	logic [15:0] ch0_result = 0, low_thresh = 0, high_thresh = 0;
	logic [1:0]  lag = 0;
	logic        int_clear, int_n;
	int          num_errors = 0, n_checks = 0, run = 0, k;
	always #50 core_clk = ~core_clk;
	lsi_int_ctrl lsi_int_ctrl_inst (.core_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
		.reg_rd_data, .int_clear, .conv_done, .ch0_result, .low_thresh, .high_thresh, .int_n);
	lsi_host_model lsi_host_model_inst (.core_clk, .int_n, .ack_en, .lag, .int_clear);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t pin got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Idle edge first, so a strobe is never lowered and raised in one step
	task automatic wr(input logic [7:0] v);
		@(negedge core_clk);
		reg_wr_en   = 1;
		reg_addr    = LSI_CFG_ADDR;
		reg_wr_data = v;
		@(negedge core_clk) reg_wr_en = 0;
		cfg = {2'h0, v[5:0]};
		if (v[5:4] != LSI_MODE_LEVEL)
			exp_n = 1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(negedge core_clk);
		reg_rd_en = 1;
		reg_addr  = a;
		@(negedge core_clk) reg_rd_en = 0;
		chk(reg_rd_data, exp);
	endtask
	task automatic conv(input logic [15:0] v);
		logic o;
		@(negedge core_clk);
		o          = v <= low_thresh || v > high_thresh;
		conv_done  = 1;
		ch0_result = v;
		@(negedge core_clk) conv_done = 0;
		run = o ? (run < 15 ? run + 1 : 15) : 0;
		if (cfg[5:4] == LSI_MODE_LEVEL && (cfg[3:0] == 0 || (o && run >= cfg[3:0])))
			exp_n = 0;
		chk_pin(int_n, exp_n);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#5000000;
		num_errors++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(32'h203856CB));
		repeat (10) @(negedge core_clk);
		rst_n = 1;
		rd(LSI_CFG_ADDR, LSI_CFG_RESET);
		rd(4'h9, 8'h00);
		repeat (500)
		begin
			if ($urandom % 12 == 0)
			begin
				low_thresh  = 16'($urandom) & 16'h7FFF;
				high_thresh = low_thresh + (16'($urandom) & 16'h3FFF);
				d           = 8'($urandom);
				if (d[7])
					d[5:4] = LSI_MODE_LEVEL;
				if (d[6])
					d[3] = 1'b0;
				wr({2'h0, d[5:0]});
				rd(LSI_CFG_ADDR, cfg);
			end
			k = $urandom % 4;
			conv(k == 0 ? low_thresh : k == 1 ? high_thresh + 16'h1 : k == 2 ? high_thresh : 16'($urandom));
			repeat ($urandom % 3) @(negedge core_clk);
		end
		// Drop any pending pin first, or the latency count starts short
		wr(8'h00);
		wr(8'h10);
		ack_en = 1;
		for (int l = 0; l < 4; l++)
		begin
			lag = 2'(l);
			conv(high_thresh);
			k = 0;
			while (int_n !== 1'b1 && k < 10)
			begin
				@(negedge core_clk);
				k++;
			end
			exp_n = 1;
			chk(8'(k), 8'(l + 1));
		end
		tally_and_finish();
	end
endmodule
